// file: cmsd_strap_decoder.sv
// Clock mode strap decoder: captures clocking straps at power-on reset and sets up PLL and divider ratios.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
module cmsd_strap_decoder
    import cmsd_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_on_reset_in,
    input wire logic pci_clock_mode_select,
    input wire logic host_agent_select,
    input wire logic pci_freq_range_select,
    input wire logic [2:0] clock_ratio_pins,
    input wire logic [3:0] clock_ratio_high_nibble,
    input wire logic test_clock,
    input wire logic test_reset,
    input wire logic test_mode_select,
    input wire logic test_data_in,
    output logic test_data_out,
    output logic test_data_out_enable,
    output logic [1:0] clock_mode,
    output logic pci_range_low,
    output logic [6:0] ratio_code,
    output logic [4:0] cpm_mult_x2,
    output logic [4:0] core_mult_x2,
    output logic config_valid,
    output logic config_reserved,
    output logic pll_setup_enable
);

    initial begin
        if (ADDR_WIDTH < 4 || ADDR_WIDTH > 32) begin
            $error("cmsd_strap_decoder: ADDR_WIDTH must lie between 4 and 32");
        end
    end

    // Returns the peripheral and core multipliers in half steps, with a leading flag for a code without an entry.
    function automatic logic [10:0] cmsd_decode_ratio(input cmsd_mode_type mode, input logic [6:0] code);
        logic [10:0] result;
        result = {1'b1, 5'h00, 5'h00};
        if (mode == CMSD_LOCAL_BUS) begin
            unique case (code)
                7'h00: result = {1'b0, 5'h06, 5'h08};
                7'h01: result = {1'b0, 5'h06, 5'h0a};
                7'h02: result = {1'b0, 5'h08, 5'h08};
                7'h03: result = {1'b0, 5'h08, 5'h0a};
                7'h04: result = {1'b0, 5'h04, 5'h05};
                7'h05: result = {1'b0, 5'h04, 5'h06};
                7'h06: result = {1'b0, 5'h05, 5'h05};
                7'h07: result = {1'b0, 5'h05, 5'h06};
                CMSD_CODE_FULL_FIRST: result = {1'b0, 5'h04, 5'h08};
                default: result = {1'b1, 5'h00, 5'h00};
            endcase
        end
        return result;
    endfunction : cmsd_decode_ratio

    // Compares a bus address with a register offset over the implemented address bits.
    function automatic logic cmsd_addr_is(input logic [ADDR_WIDTH-1:0] addr, input logic [11:0] offset);
        logic [31:0] wide_addr;
        wide_addr = 32'h0;
        wide_addr[ADDR_WIDTH-1:0] = addr;
        return wide_addr == {20'h00000, offset};
    endfunction : cmsd_addr_is

    logic [CMSD_STRAP_WIDTH-1:0] strap_meta;
    logic [CMSD_STRAP_WIDTH-1:0] strap_sync;
    logic por_prev;
    cmsd_mode_type mode;
    logic range_low;
    logic [6:0] code;
    logic valid;
    logic [31:0] ctrl;
    logic [31:0] next_prdata;

    // Straps and power-on reset come from pins and pass two flip-flops before any use.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            strap_meta <= '0;
            strap_sync <= '0;
        end else begin
            strap_meta <= {power_on_reset_in, pci_clock_mode_select, host_agent_select, pci_freq_range_select,
                           clock_ratio_high_nibble, clock_ratio_pins};
            strap_sync <= strap_meta;
        end
    end

    wire live_por = strap_sync[CMSD_STRAPS_POR_BIT];
    wire live_pci_mode = strap_sync[CMSD_STRAPS_PCI_MODE_BIT];
    wire live_host_agent = strap_sync[CMSD_STRAPS_HOST_AGENT_BIT];
    wire live_range = strap_sync[CMSD_STRAPS_RANGE_BIT];
    wire [3:0] live_nibble = strap_sync[CMSD_STRAPS_NIBBLE_LSB +: 4];
    wire [2:0] live_ratio = strap_sync[CMSD_STRAPS_RATIO_LSB +: 3];
    wire por_release = por_prev & ~live_por;

    // Mode selection from the strap pins.
    wire cmsd_mode_type live_mode = (live_pci_mode == CMSD_PCI_MODE_LOCAL) ? CMSD_LOCAL_BUS :
                                    (live_host_agent == CMSD_SELECT_HOST) ? CMSD_PCI_HOST :
                                    CMSD_PCI_AGENT;
    // The range pin only means something once a PCI mode is chosen.
    wire live_range_low = (live_mode != CMSD_LOCAL_BUS) && (live_range != CMSD_RANGE_50_66);
    wire [6:0] live_code = {live_nibble, live_ratio};

    // The captured setting moves only at the release of power-on reset and is withdrawn while it is held.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            por_prev <= 1'b0;
            mode <= CMSD_LOCAL_BUS;
            range_low <= 1'b0;
            code <= CMSD_CODE_RESET;
            valid <= 1'b0;
        end else begin
            por_prev <= live_por;
            if (live_por) begin
                valid <= 1'b0;
            end else if (por_release) begin
                mode <= live_mode;
                range_low <= live_range_low;
                code <= live_code;
                valid <= 1'b1;
            end
        end
    end

    wire [10:0] decoded = cmsd_decode_ratio(mode, code);
    wire decoded_reserved = decoded[10];

    // Settings handed to the PLL and dividers, registered so they change only with the captured state and the control register's PLL enable bit.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clock_mode <= 2'h0;
            pci_range_low <= 1'b0;
            ratio_code <= CMSD_CODE_RESET;
            cpm_mult_x2 <= 5'h00;
            core_mult_x2 <= 5'h00;
            config_valid <= 1'b0;
            config_reserved <= 1'b0;
            pll_setup_enable <= 1'b0;
        end else begin
            clock_mode <= mode;
            pci_range_low <= range_low;
            ratio_code <= code;
            cpm_mult_x2 <= decoded[9:5];
            core_mult_x2 <= decoded[4:0];
            config_valid <= valid;
            config_reserved <= valid & decoded_reserved;
            pll_setup_enable <= valid & ~decoded_reserved & ctrl[CMSD_CTRL_PLL_ENABLE_BIT];
        end
    end

    // Register bus slave: zero wait states, read data registered during the setup cycle.
    wire hit_ctrl = cmsd_addr_is(paddr, CMSD_CTRL_OFFSET);
    wire hit_status = cmsd_addr_is(paddr, CMSD_STATUS_OFFSET);
    wire hit_ratio = cmsd_addr_is(paddr, CMSD_RATIO_OFFSET);
    wire hit_straps = cmsd_addr_is(paddr, CMSD_STRAPS_OFFSET);
    wire addr_hit = hit_ctrl | hit_status | hit_ratio | hit_straps;
    wire setup_phase = psel & ~penable;
    wire write_ctrl = psel & penable & pwrite & hit_ctrl & pstrb[0];

    wire [31:0] status_word = {17'h00000, code, 2'h0, live_por, valid & decoded_reserved, range_low, 2'(mode), valid};
    wire [31:0] ratio_word = {19'h00000, decoded[4:0], 3'h0, decoded[9:5]};
    wire [31:0] straps_word = {21'h000000, strap_sync};

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (!pwrite) begin
            if (hit_ctrl) begin
                next_prdata = ctrl;
            end else if (hit_status) begin
                next_prdata = status_word;
            end else if (hit_ratio) begin
                next_prdata = ratio_word;
            end else if (hit_straps) begin
                next_prdata = straps_word;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata <= next_prdata;
            pslverr <= ~addr_hit | (pwrite & ~hit_ctrl);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl <= CMSD_CTRL_RESET;
        end else if (write_ctrl) begin
            ctrl[CMSD_CTRL_PLL_ENABLE_BIT] <= pwdata[CMSD_CTRL_PLL_ENABLE_BIT];
        end
    end

    assign pready = 1'b1;

    // The test port captures the low CMSD_SCAN_WIDTH bits of the status word; its clock may stop at any time without harm.
    cmsd_test_port #(
        .SCAN_WIDTH(CMSD_SCAN_WIDTH)
    ) test_port (
        .clock(clock),
        .rst(rst),
        .test_clock(test_clock),
        .test_reset(test_reset),
        .test_mode_select(test_mode_select),
        .test_data_in(test_data_in),
        .capture_word(status_word[CMSD_SCAN_WIDTH-1:0]),
        .test_data_out(test_data_out),
        .test_data_out_enable(test_data_out_enable)
    );

endmodule : cmsd_strap_decoder

// file: cmsd_pkg.sv
// Constants, field layouts and types shared by the clock mode strap decoder.
package cmsd_pkg;

    typedef enum logic [1:0] {
        CMSD_LOCAL_BUS,
        CMSD_PCI_HOST,
        CMSD_PCI_AGENT
    } cmsd_mode_type;

    localparam int CMSD_DATA_WIDTH = 32;

    // Register byte offsets.
    localparam logic [11:0] CMSD_CTRL_OFFSET = 12'h000;
    localparam logic [11:0] CMSD_STATUS_OFFSET = 12'h004;
    localparam logic [11:0] CMSD_RATIO_OFFSET = 12'h008;
    localparam logic [11:0] CMSD_STRAPS_OFFSET = 12'h00c;

    // Control register fields and reset value.
    localparam int CMSD_CTRL_PLL_ENABLE_BIT = 0;
    localparam logic [31:0] CMSD_CTRL_RESET = 32'h0000_0000;

    // Status register fields.
    localparam int CMSD_STATUS_VALID_BIT = 0;
    localparam int CMSD_STATUS_MODE_LSB = 1;
    localparam int CMSD_STATUS_RANGE_BIT = 3;
    localparam int CMSD_STATUS_RESERVED_BIT = 4;
    localparam int CMSD_STATUS_POR_BIT = 5;
    localparam int CMSD_STATUS_CODE_LSB = 8;

    // Ratio register fields, multipliers held in half steps.
    localparam int CMSD_RATIO_CPM_LSB = 0;
    localparam int CMSD_RATIO_CORE_LSB = 8;
    localparam int CMSD_MULT_WIDTH = 5;

    // Live strap register fields.
    localparam int CMSD_STRAPS_RATIO_LSB = 0;
    localparam int CMSD_STRAPS_NIBBLE_LSB = 3;
    localparam int CMSD_STRAPS_RANGE_BIT = 7;
    localparam int CMSD_STRAPS_HOST_AGENT_BIT = 8;
    localparam int CMSD_STRAPS_PCI_MODE_BIT = 9;
    localparam int CMSD_STRAPS_POR_BIT = 10;
    localparam int CMSD_STRAP_WIDTH = 11;

    // Seven-bit ratio code: high nibble over the three ratio pins.
    localparam int CMSD_CODE_WIDTH = 7;
    localparam logic [6:0] CMSD_CODE_RESET = 7'h00;
    localparam logic [6:0] CMSD_CODE_FULL_FIRST = 7'h08;

    // Strap pin level that forces local bus clocking.
    localparam logic CMSD_PCI_MODE_LOCAL = 1'b1;
    // Host/agent pin level that selects the host.
    localparam logic CMSD_SELECT_HOST = 1'b0;
    // Range pin level for the 50 to 66 MHz range.
    localparam logic CMSD_RANGE_50_66 = 1'b0;

    // Test port capture word width.
    localparam int CMSD_SCAN_WIDTH = 16;

endpackage : cmsd_pkg

// file: cmsd_test_port.sv
// Test port: samples mode select and serial data on test clock rising edges, launches output on falling edges.
`timescale 1ns/10ps
module cmsd_test_port
    import cmsd_pkg::*;
#(
    parameter int SCAN_WIDTH = CMSD_SCAN_WIDTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic test_clock,
    input wire logic test_reset,
    input wire logic test_mode_select,
    input wire logic test_data_in,
    input wire logic [SCAN_WIDTH-1:0] capture_word,
    output logic test_data_out,
    output logic test_data_out_enable
);

    initial begin
        if (SCAN_WIDTH < 2) begin
            $error("cmsd_test_port: SCAN_WIDTH must be at least 2");
        end
    end

    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic clock_prev;
    logic [SCAN_WIDTH-1:0] scan;
    logic shifting;

    wire test_logic_reset = rst | test_reset;
    wire sync_clock = pin_sync[2];
    wire sync_mode_select = pin_sync[1];
    wire sync_data_in = pin_sync[0];
    wire clock_rise = sync_clock & ~clock_prev;
    wire clock_fall = ~sync_clock & clock_prev;

    // Test clock, mode select and data share one synchroniser so they keep their relative timing.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= {test_clock, test_mode_select, test_data_in};
            pin_sync <= pin_meta;
        end
    end

    // The test reset acts at once and holds the test logic for as long as it stays high.
    always_ff @(posedge clock or posedge test_logic_reset) begin
        if (test_logic_reset) begin
            clock_prev <= 1'b0;
            scan <= '0;
            shifting <= 1'b0;
        end else begin
            clock_prev <= sync_clock;
            if (clock_rise) begin
                shifting <= ~sync_mode_select;
                if (sync_mode_select) begin
                    scan <= capture_word;
                end else begin
                    scan <= {sync_data_in, scan[SCAN_WIDTH-1:1]};
                end
            end
        end
    end

    always_ff @(posedge clock or posedge test_logic_reset) begin
        if (test_logic_reset) begin
            test_data_out <= 1'b0;
            test_data_out_enable <= 1'b0;
        end else if (clock_fall) begin
            test_data_out <= scan[0];
            test_data_out_enable <= shifting;
        end
    end

endmodule : cmsd_test_port

// file: cmsd_strap_decoder_asserts.sv
// Concurrent checks on the ports of the clock mode strap decoder.
`timescale 1ns/10ps
module cmsd_strap_decoder_asserts
    import cmsd_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic power_on_reset_in,
    input wire logic test_clock,
    input wire logic test_reset,
    input wire logic test_data_out,
    input wire logic test_data_out_enable,
    input wire logic [1:0] clock_mode,
    input wire logic pci_range_low,
    input wire logic [6:0] ratio_code,
    input wire logic [4:0] cpm_mult_x2,
    input wire logic [4:0] core_mult_x2,
    input wire logic config_valid,
    input wire logic config_reserved,
    input wire logic pll_setup_enable
);
    // Core and peripheral multipliers, both doubled, for local codes 0x00 to 0x08.
    localparam logic [9:0] MULT_TAB [9] = '{10'h106, 10'h146, 10'h108, 10'h148, 10'h0a4,
        10'h0c4, 10'h0a5, 10'h0c5, 10'h104};

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    mode_legal_a: assert property (clock_mode != 2'h3)
        else $error("clock mode outside the three modes");
    local_range_a: assert property (clock_mode == CMSD_LOCAL_BUS |-> !pci_range_low)
        else $error("range flag set in local bus mode");
    ratio_table_a: assert property (config_valid && clock_mode == CMSD_LOCAL_BUS && ratio_code <= 7'h08
        |-> {core_mult_x2, cpm_mult_x2} == MULT_TAB[ratio_code]) else $error("multipliers differ from table");
    pci_reserved_a: assert property (config_valid && clock_mode != CMSD_LOCAL_BUS |-> config_reserved)
        else $error("pci mode not flagged reserved");
    pll_gate_a: assert property (pll_setup_enable |-> config_valid && !config_reserved)
        else $error("pll setup without valid config");
    config_hold_a: assert property (!power_on_reset_in [*8] |=> $stable(ratio_code) && $stable(clock_mode))
        else $error("config moved without power on reset");
    por_blank_a: assert property (power_on_reset_in [*4] |=> !config_valid)
        else $error("config valid while power on reset held");
    unmapped_a: assert property (psel && !penable && paddr > 12'h00c |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    ratio_read_a: assert property (psel && penable && !pwrite && paddr == CMSD_RATIO_OFFSET
        |-> prdata[4:0] == cpm_mult_x2 && prdata[12:8] == core_mult_x2) else $error("ratio read wrong");
    scan_reset_a: assert property (test_reset [*2] |-> !test_data_out_enable && !test_data_out)
        else $error("test output active in test reset");
    tdo_fall_a: assert property (!test_reset && $changed(test_data_out) |-> !test_clock)
        else $error("test output changed with test clock high");

    cover property (config_valid && clock_mode == CMSD_LOCAL_BUS && ratio_code == 7'h08);
    cover property (pll_setup_enable);
    cover property (test_data_out_enable && test_data_out);
endmodule : cmsd_strap_decoder_asserts

// file: cmsd_strap_board.sv
// Board model that drives the clocking straps and the power-on reset pin.
`timescale 1ns/10ps
module cmsd_strap_board (
    input wire logic clock,
    output logic power_on_reset_in,
    output logic pci_clock_mode_select,
    output logic host_agent_select,
    output logic pci_freq_range_select,
    output logic [2:0] clock_ratio_pins,
    output logic [3:0] clock_ratio_high_nibble
);
    initial begin
        power_on_reset_in = 1'b1;
        {pci_clock_mode_select, host_agent_select, pci_freq_range_select} = 3'h4;
        {clock_ratio_high_nibble, clock_ratio_pins} = 7'h00;
    end

    // Straps settle well before the reset pin falls and stay put past it.
    task automatic power_on(input logic [9:0] s);
        @(posedge clock);
        power_on_reset_in <= 1'b1;
        drift(s);
        repeat (8) @(posedge clock);
        power_on_reset_in <= 1'b0;
        repeat (8) @(posedge clock);
    endtask : power_on

    task automatic drift(input logic [9:0] s);
        {pci_clock_mode_select, host_agent_select, pci_freq_range_select,
            clock_ratio_high_nibble, clock_ratio_pins} <= s;
    endtask : drift
endmodule : cmsd_strap_board

// file: cmsd_strap_decoder_test.sv
// Self-checking bench for the clock mode strap decoder.
`timescale 1ns/10ps
module cmsd_strap_decoder_test;
    import cmsd_pkg::*;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic power_on_reset_in, pci_clock_mode_select, host_agent_select, pci_freq_range_select;
    logic [2:0] clock_ratio_pins;
    logic [3:0] clock_ratio_high_nibble;
    logic test_clock, test_reset, test_mode_select, test_data_in, test_data_out, test_data_out_enable;
    logic [1:0] clock_mode;
    logic pci_range_low, config_valid, config_reserved, pll_setup_enable;
    logic [6:0] ratio_code;
    logic [4:0] cpm_mult_x2, core_mult_x2;
    logic [9:0] mult_tab [9] = '{10'h106, 10'h146, 10'h108, 10'h148, 10'h0a4, 10'h0c4, 10'h0a5, 10'h0c5, 10'h104};
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;

    cmsd_strap_decoder u_dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .power_on_reset_in, .pci_clock_mode_select, .host_agent_select,
        .pci_freq_range_select, .clock_ratio_pins, .clock_ratio_high_nibble, .test_clock, .test_reset,
        .test_mode_select, .test_data_in, .test_data_out, .test_data_out_enable, .clock_mode,
        .pci_range_low, .ratio_code, .cpm_mult_x2, .core_mult_x2, .config_valid, .config_reserved,
        .pll_setup_enable);
    cmsd_strap_board u_board (.clock, .power_on_reset_in, .pci_clock_mode_select, .host_agent_select,
        .pci_freq_range_select, .clock_ratio_pins, .clock_ratio_high_nibble);

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] exp_status(input logic [1:0] m, input logic r, v, input logic [6:0] c);
        return {17'h0, c, 3'h0, v, r, m, 1'b1};
    endfunction : exp_status

    // Mode select and data are set well clear of the rising test clock edge.
    task automatic tck(input logic tms, input logic tdi);
        test_mode_select <= tms;
        test_data_in <= tdi;
        repeat (4) @(posedge clock);
        test_clock <= 1'b1;
        repeat (8) @(posedge clock);
        test_clock <= 1'b0;
        repeat (8) @(posedge clock);
    endtask : tck

    task automatic t_regs;
        apb(1'b0, CMSD_CTRL_OFFSET, 32'h0);
        check("ctrl reset", rd, CMSD_CTRL_RESET);
        check("valid in por", 32'(config_valid), 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped err", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, CMSD_RATIO_OFFSET, 32'hffff_ffff);
        check("ro write err", 32'(err), 32'h1);
    endtask : t_regs

    task automatic t_local;
        logic [6:0] c;
        for (int i = 0; i < 10; i++) begin
            c = 7'(i);
            u_board.power_on({1'b1, c[0], c[1], c});
            check("mode", 32'(clock_mode), 32'(CMSD_LOCAL_BUS));
            check("code", 32'(ratio_code), 32'(c));
            check("valid", 32'(config_valid), 32'h1);
            check("range", 32'(pci_range_low), 32'h0);
            check("reserved", 32'(config_reserved), 32'(i == 9));
            if (i < 9) begin
                check("mult", 32'({core_mult_x2, cpm_mult_x2}), 32'(mult_tab[i]));
                apb(1'b0, CMSD_RATIO_OFFSET, 32'h0);
                check("ratio reg", rd, {19'h0, mult_tab[i][9:5], 3'h0, mult_tab[i][4:0]});
            end
            apb(1'b0, CMSD_STATUS_OFFSET, 32'h0);
            check("status", rd, exp_status(2'h0, 1'b0, i == 9, c));
            if (i == 8) apb(1'b1, CMSD_CTRL_OFFSET, 32'h1);
            repeat (2) @(posedge clock);
            check("pll", 32'(pll_setup_enable), 32'(i == 8));
        end
    endtask : t_local

    task automatic t_pci;
        for (int i = 0; i < 4; i++) begin
            u_board.power_on({1'b0, 2'(i), 7'h05});
            check("pci mode", 32'(clock_mode), 32'((i > 1) ? CMSD_PCI_AGENT : CMSD_PCI_HOST));
            check("pci range", 32'(pci_range_low), 32'(i % 2));
            check("pci pll", 32'(pll_setup_enable), 32'h0);
        end
    endtask : t_pci

    task automatic t_hold;
        u_board.power_on(10'h203);
        u_board.drift(10'h1fc);
        repeat (10) @(posedge clock);
        check("held code", 32'(ratio_code), 32'h3);
        check("held mode", 32'(clock_mode), 32'(CMSD_LOCAL_BUS));
        apb(1'b0, CMSD_STRAPS_OFFSET, 32'h0);
        check("live straps", rd, 32'h1fc);
    endtask : t_hold

    task automatic t_scan;
        logic [31:0] w;
        w = exp_status(2'h0, 1'b0, 1'b0, 7'h3);
        check("oe in reset", 32'(test_data_out_enable), 32'h0);
        test_reset <= 1'b0;
        tck(1'b1, 1'b0);
        for (int k = 1; k < 16; k++) begin
            tck(1'b0, 1'b1);
            check("tdo", 32'(test_data_out), 32'(w[k]));
            check("oe", 32'(test_data_out_enable), 32'h1);
        end
        test_reset <= 1'b1;
        repeat (2) @(posedge clock);
        check("oe cleared", 32'(test_data_out_enable), 32'h0);
    endtask : t_scan

    task automatic conclude;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        {test_clock, test_mode_select, test_data_in} = 3'h0;
        test_reset = 1'b1;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_local();
        t_pci();
        t_hold();
        t_scan();
        conclude();
    end
endmodule : cmsd_strap_decoder_test

bind cmsd_strap_decoder cmsd_strap_decoder_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.clock, .rst, .psel,
    .penable, .pwrite, .paddr, .prdata, .pslverr, .power_on_reset_in, .test_clock, .test_reset, .test_data_out,
    .test_data_out_enable, .clock_mode, .pci_range_low, .ratio_code, .cpm_mult_x2, .core_mult_x2,
    .config_valid, .config_reserved, .pll_setup_enable);
